// *** hw/pdsq_power_slot.sv ***
// Purpose: one analog subsystem: enable plus power-on settle timer
// Assumes: settle time of POWER_ON_CYCLES clocks after enable rises
// Notes:   ready drops in the cycle after the enable falls
module pdsq_power_slot
  import pdsq_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // control
  input  wire logic enable,
  // status
  output logic      ready
);

  logic [PON_CNT_W-1:0] count;
  logic [PON_CNT_W-1:0] next_count;
  logic                 next_ready;

  // ------------------------------------------------------------------
  // settle timer
  // ------------------------------------------------------------------
  always_comb begin
    next_count = count;
    next_ready = ready;
    if (!enable) begin
      next_count = '0;
      next_ready = 1'b0;
    end else if (!ready) begin
      if (count == PON_CNT_W'(POWER_ON_CYCLES - 1)) begin
        next_ready = 1'b1;
      end else begin
        next_count = count + PON_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      ready <= 1'b0;
    end else begin
      count <= next_count;
      ready <= next_ready;
    end
  end

  a_ready_needs_on: assert property (@(posedge clk) disable iff (!rstn)
    !enable |=> !ready) else $error("ready while disabled");

endmodule : pdsq_power_slot

// *** hw/pdsq_sequencer.sv ***
// Purpose: powerdown control/status and reset-time clocking selection
// Assumes: register strobes already decoded from the serial link
// Notes:   rstn is the cold reset; straps caught after its release
// Function
// - seven-bit powerdown request field, any bit combination allowed
// - clearing a request resumes its subsystem, except link and clock bits
// - ADC request shuts ADCs and input mux and clears ADC ready
// - DAC, mixer, reference, headphone requests clear their ready flags
// - cleared request starts power-on; ready set when hardware is ready
// - link request stops link and bit clock, primary codec only
// - clock stop halts internal clocks, ADCs, DACs; bit clock, mixer run
// - after clock stop only a cold reset restores operation
// - link and clock requests in one frame hold the bit clock low
// - mixer requests also power down ADCs, DACs, headphone; one drops ref
// - clocking picked from clock input presence and two id straps
// - clock present and a strap low at reset release selects PLL mode, loop filter pin
// - in PLL mode the straps select the divider ratios
// - strap codes map to 24.576, 14.31818, 27.000, 48.000 MHz inputs
// - PLL mode is always primary codec
// - clock present and straps high: PLL off, input used directly
// - in PLL mode both id fields read zero
// - no clock at reset release: PLL input off, straps latched
// - no clock and straps high: primary codec on crystal
// - no clock, a strap low: secondary, bit clock input, id 1 to 3
module pdsq_sequencer
  import pdsq_pkg::*;
(
  // clock and cold reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register access
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [6:0]  reg_index,
  input  wire logic [15:0] reg_wr_data,
  output logic [15:0]      reg_rd_data,
  output logic             reg_rd_valid,
  // link events
  input  wire logic        frame_start,
  input  wire logic        warm_reset,
  input  wire logic        new_warm_reset,
  // straps and clock detect
  input  wire logic        clock_input_valid,
  input  wire logic [1:0]  codec_id_straps_n,
  // power controls
  output logic [4:0]       subsys_power_on,
  output logic             link_shutdown,
  output logic             internal_clock_stop,
  output logic             bit_clk_run,
  output logic             bit_clk_hold_low,
  // clocking configuration
  output logic             config_valid,
  output logic             pll_enable,
  output logic             loop_filter_mode,
  output logic [1:0]       divider_select,
  output logic             primary_codec,
  output logic             bit_clk_oe_n,
  output logic [1:0]       codec_id
);

  localparam int SETTLE_MAX = 24;

  // ------------------------------------------------------------------
  // clocking configuration, caught once after reset release
  // ------------------------------------------------------------------
  pdsq_cfg_e  cfg_state;
  pdsq_cfg_e  next_cfg_state;
  pdsq_mode_e mode;
  pdsq_mode_e next_mode;
  logic [1:0] straps;
  logic [1:0] next_straps;

  always_comb begin
    next_cfg_state = cfg_state;
    next_mode      = mode;
    next_straps    = straps;
    case (cfg_state)
      CFG_WAIT: begin
        next_straps    = codec_id_straps_n;
        next_cfg_state = CFG_HELD;
        if (clock_input_valid) begin
          if (codec_id_straps_n == STRAP_24M576) begin
            next_mode = MODE_EXT_DIRECT;
          end else begin
            next_mode = MODE_EXT_PLL;
          end
        end else if (codec_id_straps_n == STRAP_24M576) begin
          next_mode = MODE_XTAL;
        end else begin
          next_mode = MODE_SECONDARY;
        end
      end
      CFG_HELD: begin
        next_cfg_state = CFG_HELD;
      end
      default: begin
        next_cfg_state = CFG_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_state <= CFG_WAIT;
      mode      <= MODE_XTAL;
      straps    <= STRAP_24M576;
    end else begin
      cfg_state <= next_cfg_state;
      mode      <= next_mode;
      straps    <= next_straps;
    end
  end

  // config outputs straight from the held state
  always_comb begin
    config_valid     = (cfg_state == CFG_HELD);
    pll_enable       = (mode == MODE_EXT_PLL);
    loop_filter_mode = (mode == MODE_EXT_PLL);
    divider_select   = straps;
    primary_codec    = (mode != MODE_SECONDARY);
    bit_clk_oe_n     = (mode == MODE_SECONDARY);
    codec_id         = primary_codec ? ID_PRIMARY : ~straps;
  end

  // ------------------------------------------------------------------
  // powerdown request field
  // ------------------------------------------------------------------
  logic [6:0] pr;
  logic [6:0] next_pr;
  logic [1:0] set_in_frame;
  logic [1:0] next_set_in_frame;
  logic       digital_off;
  logic       next_digital_off;
  logic       pcs_wr;
  logic [6:0] wr_pr;

  always_comb begin
    pcs_wr  = reg_wr && reg_index == PCS_INDEX && !pr[PR_CLK];
    wr_pr   = reg_wr_data[PR_LSB +: PR_WIDTH];
    next_pr = pr;
    if (pcs_wr) begin
      next_pr = wr_pr;
      next_pr[PR_LINK] = pr[PR_LINK] | wr_pr[PR_LINK];
      next_pr[PR_CLK]  = wr_pr[PR_CLK];
    end
    // a link request in the same cycle as a wake keeps the link down
    if ((warm_reset || new_warm_reset) && !pr[PR_CLK]
        && !(pcs_wr && wr_pr[PR_LINK])) begin
      next_pr[PR_LINK] = 1'b0;
    end
    // a frame opening starts a fresh window; a set in it still counts
    next_set_in_frame = frame_start ? 2'b00 : set_in_frame;
    if (pcs_wr && wr_pr[PR_LINK] && !pr[PR_LINK]) begin
      next_set_in_frame[0] = 1'b1;
    end
    if (pcs_wr && wr_pr[PR_CLK]) begin
      next_set_in_frame[1] = 1'b1;
    end
    next_digital_off = digital_off | (&next_set_in_frame);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pr           <= PR_RESET;
      set_in_frame <= 2'b00;
      digital_off  <= 1'b0;
    end else begin
      pr           <= next_pr;
      set_in_frame <= next_set_in_frame;
      digital_off  <= next_digital_off;
    end
  end

  // ------------------------------------------------------------------
  // subsystem enables and link/clock controls
  // ------------------------------------------------------------------
  logic [4:0] next_power_on;
  logic       mix_off;
  logic       next_link_shutdown;
  logic       next_bit_clk_run;

  always_comb begin
    mix_off = pr[PR_MIXV] | pr[PR_MIXR];
    next_power_on[SS_ADC] = !(pr[PR_ADC] | mix_off | pr[PR_CLK]);
    next_power_on[SS_DAC] = !(pr[PR_DAC] | mix_off | pr[PR_CLK]);
    next_power_on[SS_MIX] = !mix_off;
    next_power_on[SS_REF] = !pr[PR_MIXR];
    next_power_on[SS_HP]  = !(pr[PR_HP] | mix_off);
    next_link_shutdown = pr[PR_LINK] && primary_codec;
    next_bit_clk_run   = primary_codec && !next_link_shutdown
                         && !digital_off;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      subsys_power_on     <= '0;
      link_shutdown       <= 1'b0;
      internal_clock_stop <= 1'b0;
      bit_clk_run         <= 1'b0;
      bit_clk_hold_low    <= 1'b0;
    end else begin
      subsys_power_on     <= next_power_on;
      link_shutdown       <= next_link_shutdown;
      internal_clock_stop <= pr[PR_CLK];
      bit_clk_run         <= next_bit_clk_run;
      bit_clk_hold_low    <= digital_off;
    end
  end

  // ------------------------------------------------------------------
  // ready flags per subsystem
  // ------------------------------------------------------------------
  logic [4:0] ready;

  for (genvar i = 0; i < NUM_SUBSYS; i++) begin : g_slot
    pdsq_power_slot u_slot (
      .clk    (clk),
      .rstn   (rstn),
      .enable (subsys_power_on[i]),
      .ready  (ready[i])
    );
  end

  // ------------------------------------------------------------------
  // register read
  // ------------------------------------------------------------------
  logic [15:0] next_rd_data;

  always_comb begin
    next_rd_data = RD_IDLE;
    case (reg_index)
      PCS_INDEX: begin
        next_rd_data[PR_LSB +: PR_WIDTH] = pr;
        next_rd_data[NUM_SUBSYS-1:0]     = ready;
      end
      EXT_AUDIO_INDEX: begin
        next_rd_data[ID_LSB +: 2] = codec_id;
      end
      EXT_MODEM_INDEX: begin
        next_rd_data[ID_LSB +: 2] = codec_id;
      end
      default: begin
        next_rd_data = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rd_data  <= RD_IDLE;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rd_data <= next_rd_data;
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_adc_ready_drop: assert property (
    pcs_wr && wr_pr[PR_ADC] |-> ##3 !ready[SS_ADC])
    else $error("adc ready not cleared");
  a_ready_return: assert property (
    $rose(subsys_power_on[SS_DAC]) |-> ##[1:SETTLE_MAX] ready[SS_DAC])
    else $error("dac ready late");
  a_link_primary: assert property (
    !primary_codec |-> !link_shutdown)
    else $error("link shutdown on secondary");
  a_clock_stop_hold: assert property (
    pr[PR_CLK] && (warm_reset || new_warm_reset) && pr[PR_LINK]
    |=> pr[PR_CLK] && pr[PR_LINK])
    else $error("recovered from clock stop");
  a_clock_stop_effect: assert property (
    pr[PR_CLK] && !mix_off |=> !subsys_power_on[SS_ADC]
    && !subsys_power_on[SS_DAC] && subsys_power_on[SS_MIX])
    else $error("clock stop enables wrong");
  a_digital_off_low: assert property (
    digital_off |=> bit_clk_hold_low && !bit_clk_run)
    else $error("bit clock not held low");
  a_mixer_cascade: assert property (
    pr[PR_MIXV] |=> !subsys_power_on[SS_ADC] && !subsys_power_on[SS_HP]
    && !subsys_power_on[SS_DAC])
    else $error("mixer cascade missing");
  a_pll_id_zero: assert property (
    reg_rd && reg_index == EXT_AUDIO_INDEX && pll_enable
    |=> reg_rd_data[ID_LSB +: 2] == 2'b00 && primary_codec)
    else $error("pll id not zero");
  a_config_stable: assert property (
    config_valid |=> config_valid && $stable(divider_select)
    && $stable(pll_enable) && $stable(bit_clk_oe_n))
    else $error("clocking changed");
  a_secondary_dir: assert property (
    config_valid && !primary_codec |-> bit_clk_oe_n && codec_id != 2'b00)
    else $error("secondary wrong");

  c_pll_mode: cover property (config_valid && pll_enable);
  c_secondary: cover property (config_valid && !primary_codec);
  c_digital_off: cover property ($rose(bit_clk_hold_low));
  c_warm_resume: cover property ($fell(link_shutdown));

endmodule : pdsq_sequencer

// *** inc/pdsq_pkg.sv ***
// Purpose: constants and types for the powerdown and clocking block
// Assumes: 20 MHz core clock, 7-bit register index, 16-bit register data
// Notes:   shared by the sequencer and its subsystem power slot
package pdsq_pkg;

  // ------------------------------------------------------------------
  // register indices and fields
  // ------------------------------------------------------------------
  localparam logic [6:0]  PCS_INDEX       = 7'h26;
  localparam logic [6:0]  EXT_AUDIO_INDEX = 7'h28;
  localparam logic [6:0]  EXT_MODEM_INDEX = 7'h3c;
  localparam int          PR_LSB          = 8;
  localparam int          PR_WIDTH        = 7;
  localparam int          ID_LSB          = 14;
  localparam logic [6:0]  PR_RESET        = 7'h00;
  localparam logic [15:0] RD_IDLE         = 16'h0000;

  // powerdown request bit positions
  localparam int PR_ADC  = 0;
  localparam int PR_DAC  = 1;
  localparam int PR_MIXV = 2;
  localparam int PR_MIXR = 3;
  localparam int PR_LINK = 4;
  localparam int PR_CLK  = 5;
  localparam int PR_HP   = 6;

  // subsystem ready flags, also status bit positions
  localparam int NUM_SUBSYS = 5;
  localparam int SS_ADC     = 0;
  localparam int SS_DAC     = 1;
  localparam int SS_MIX     = 2;
  localparam int SS_REF     = 3;
  localparam int SS_HP      = 4;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ         = 20;
  localparam int POWER_ON_NS     = 1000;
  localparam int POWER_ON_CYCLES = (POWER_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int PON_CNT_W       = 5;

  // ------------------------------------------------------------------
  // strap codes, active-low straps as sampled
  // ------------------------------------------------------------------
  localparam logic [1:0] STRAP_24M576 = 2'b11;
  localparam logic [1:0] STRAP_14M318 = 2'b10;
  localparam logic [1:0] STRAP_27M    = 2'b01;
  localparam logic [1:0] STRAP_48M    = 2'b00;
  localparam logic [1:0] ID_PRIMARY   = 2'b00;

  typedef enum logic {CFG_WAIT, CFG_HELD} pdsq_cfg_e;
  typedef enum logic [1:0] {
    MODE_EXT_DIRECT, MODE_EXT_PLL, MODE_XTAL, MODE_SECONDARY
  } pdsq_mode_e;

endpackage : pdsq_pkg

// *** tb/pdsq_ctrl_model.sv ***
// Purpose: controller side of the link: frame pulses and wake events
// Assumes: one core clock, frames of FRAME_CYCLES clocks
// Notes:   wake pulses last one cycle, sent when the bench asks
module pdsq_ctrl_model #(
  parameter int FRAME_CYCLES = 16
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // requests from the bench
  input  wire logic want_warm,
  input  wire logic want_new_warm,
  // link events
  output logic      frame_start,
  output logic      warm_reset,
  output logic      new_warm_reset
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt            <= 0;
      frame_start    <= 1'b0;
      warm_reset     <= 1'b0;
      new_warm_reset <= 1'b0;
    end else begin
      cnt            <= (cnt == FRAME_CYCLES - 1) ? 0 : cnt + 1;
      frame_start    <= (cnt == FRAME_CYCLES - 1);
      warm_reset     <= want_warm;
      new_warm_reset <= want_new_warm;
    end
  end
endmodule : pdsq_ctrl_model

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the powerdown and clocking block
// Assumes: 20 MHz clock, ready settle of 20 cycles
// Notes:   cold reset through rstn, wake events from the controller model
module testbench
  import pdsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rstn, reg_wr, reg_rd, reg_rd_valid;
  logic [6:0]  reg_index;
  logic [15:0] reg_wr_data, reg_rd_data;
  logic        frame_start, warm_reset, new_warm_reset;
  logic        want_warm, want_new_warm, clock_input_valid;
  logic [1:0]  codec_id_straps_n, divider_select, codec_id;
  logic [4:0]  subsys_power_on;
  logic        link_shutdown, internal_clock_stop, bit_clk_run;
  logic        bit_clk_hold_low, config_valid, pll_enable;
  logic        loop_filter_mode, primary_codec, bit_clk_oe_n;
  int          mismatches, checked;

  pdsq_sequencer u_pdsq_sequencer (.clk(clk), .rstn(rstn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .frame_start(frame_start),
    .warm_reset(warm_reset), .new_warm_reset(new_warm_reset),
    .clock_input_valid(clock_input_valid),
    .codec_id_straps_n(codec_id_straps_n),
    .subsys_power_on(subsys_power_on), .link_shutdown(link_shutdown),
    .internal_clock_stop(internal_clock_stop), .bit_clk_run(bit_clk_run),
    .bit_clk_hold_low(bit_clk_hold_low), .config_valid(config_valid),
    .pll_enable(pll_enable), .loop_filter_mode(loop_filter_mode),
    .divider_select(divider_select), .primary_codec(primary_codec),
    .bit_clk_oe_n(bit_clk_oe_n), .codec_id(codec_id));
  pdsq_ctrl_model u_pdsq_ctrl_model (.clk(clk), .rstn(rstn),
    .want_warm(want_warm), .want_new_warm(want_new_warm),
    .frame_start(frame_start), .warm_reset(warm_reset),
    .new_warm_reset(new_warm_reset));

  always #25 clk = ~clk;

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic cold(input logic cv, input logic [1:0] st);
    rstn              <= 1'b0;
    clock_input_valid <= cv;
    codec_id_straps_n <= st;
    cyc(8);
    rstn <= 1'b1;
    cyc(2);
  endtask : cold

  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    reg_index   <= idx;
    reg_wr_data <= d;
    reg_wr      <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic rdchk(input logic [6:0] idx, input logic [15:0] exp,
                       input string what);
    int n;
    reg_index <= idx;
    reg_rd    <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    for (n = 0; n < 4 && reg_rd_valid !== 1'b1; n++) cyc(1);
    if (reg_rd_valid !== 1'b1) begin
      mismatches++;
      stop_test();
    end
    chk(what, exp, reg_rd_data);
  endtask : rdchk

  task automatic wait_frame();
    int n;
    for (n = 0; n < 40 && frame_start !== 1'b1; n++) cyc(1);
    if (frame_start !== 1'b1) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_frame

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_config();
    logic cv, pll, prim;
    logic [1:0] st, id;
    for (int i = 0; i < 8; i++) begin
      cv   = i[2];
      st   = i[1:0];
      pll  = cv && st != 2'b11;
      prim = cv || st == 2'b11;
      id   = prim ? 2'b00 : ~st;
      cold(cv, st);
      for (int k = 0; k < 2; k++) begin
        chk("mode", {10'h0, pll, pll, prim, !prim, id},
          {10'h0, pll_enable, loop_filter_mode, primary_codec,
          bit_clk_oe_n, codec_id});
        chk("config valid", 16'h1, {15'h0, config_valid});
        if (cv) chk("divider", {14'h0, st}, {14'h0, divider_select});
        rdchk(EXT_AUDIO_INDEX, {id, 14'h0}, "audio id");
        rdchk(EXT_MODEM_INDEX, {id, 14'h0}, "modem id");
        codec_id_straps_n <= ~st;
        clock_input_valid <= !cv;
        cyc(3);
      end
    end
    rdchk(7'h00, 16'h0000, "unmapped");
    $display("test config done");
  endtask : t_config

  task automatic t_power();
    int         pos [5] = '{0, 1, 2, 3, 6};
    logic [4:0] msk [5] = '{5'h1e, 5'h1d, 5'h08, 5'h00, 5'h0f};
    logic [15:0] req;
    cold(1'b0, 2'b11);
    cyc(22);
    rdchk(PCS_INDEX, 16'h001f, "ready at start");
    for (int i = 0; i < 5; i++) begin
      req = 16'h0001 << (PR_LSB + pos[i]);
      wr(PCS_INDEX, req);
      cyc(2);
      chk("enables", {11'h0, msk[i]}, {11'h0, subsys_power_on});
      rdchk(PCS_INDEX, req | {11'h0, msk[i]}, "status down");
      wr(PCS_INDEX, 16'h0000);
      rdchk(PCS_INDEX, {11'h0, msk[i]}, "ready early");
      cyc(22);
      rdchk(PCS_INDEX, 16'h001f, "resumed");
    end
    wr(PCS_INDEX, 16'h4300);
    cyc(2);
    chk("combined", 16'h000c, {11'h0, subsys_power_on});
    $display("test power done");
  endtask : t_power

  task automatic t_link();
    cold(1'b0, 2'b11);
    for (int k = 0; k < 2; k++) begin
      wr(PCS_INDEX, 16'h1000);
      wr(PCS_INDEX, 16'h0000);
      cyc(2);
      chk("link down", 16'h0, {15'h0, bit_clk_run});
      chk("link flag", 16'h1, {15'h0, link_shutdown});
      chk("others run", 16'h1f, {11'h0, subsys_power_on});
      if (k == 0) want_warm <= 1'b1;
      else want_new_warm <= 1'b1;
      cyc(1);
      want_warm     <= 1'b0;
      want_new_warm <= 1'b0;
      cyc(4);
      chk("link up", 16'h3, {14'h0, bit_clk_run, !link_shutdown});
    end
    $display("test link done");
  endtask : t_link

  task automatic t_clkstop();
    cold(1'b0, 2'b11);
    cyc(22);
    wr(PCS_INDEX, 16'h2000);
    cyc(3);
    chk("clock stop", 16'h1c, {internal_clock_stop, bit_clk_run, 9'h0,
      subsys_power_on} ^ 16'hc000);
    wr(PCS_INDEX, 16'h0000);
    want_warm <= 1'b1;
    cyc(1);
    want_warm <= 1'b0;
    cyc(4);
    rdchk(PCS_INDEX, 16'h201c, "frozen");
    cold(1'b0, 2'b11);
    cyc(22);
    rdchk(PCS_INDEX, 16'h001f, "cold restore");
    $display("test clock stop done");
  endtask : t_clkstop

  task automatic t_digoff();
    cold(1'b1, 2'b00);
    wait_frame();
    wr(PCS_INDEX, 16'h3000);
    cyc(2);
    chk("held low", 16'h1, {15'h0, bit_clk_hold_low});
    cold(1'b1, 2'b00);
    wait_frame();
    wr(PCS_INDEX, 16'h1000);
    cyc(1);
    wait_frame();
    wr(PCS_INDEX, 16'h3000);
    cyc(2);
    chk("split frames", 16'h0, {15'h0, bit_clk_hold_low});
    want_warm <= 1'b1;
    cyc(1);
    want_warm <= 1'b0;
    cyc(4);
    chk("link frozen", 16'h1, {15'h0, link_shutdown});
    $display("test digital off done");
  endtask : t_digoff

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk               = 1'b0;
    rstn              = 1'b0;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    reg_index         = 7'h00;
    reg_wr_data       = 16'h0000;
    want_warm         = 1'b0;
    want_new_warm     = 1'b0;
    clock_input_valid = 1'b0;
    codec_id_straps_n = 2'b11;
    mismatches        = 0;
    checked           = 0;
    cyc(1);
    t_config();
    t_power();
    t_link();
    t_clkstop();
    t_digoff();
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule : testbench
